// ---- rtl/hdp_read_port.sv ----
// read side of the host dma port with overlay control and strap capture
// assumes strobes and address arrive synchronous to clk_i from the latch logic
`timescale 1ns/100ps
module hdp_read_port
  import hdp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              port_select_n_i,
  input  wire logic              port_read_strobe_n_i,
  input  wire logic [ADDR_W-1:0] port_addr_i,
  input  wire logic              port_is_pm_i,
  output logic                   port_ack_n_o,
  input  wire logic              host_ovl_wr_i,
  input  wire logic [ADDR_W-1:0] host_ovl_addr_i,
  input  wire logic [DATA_W-1:0] host_ovl_wdata_i,
  input  wire logic              core_ovl_wr_i,
  input  wire logic [ADDR_W-1:0] core_ovl_addr_i,
  input  wire logic [DATA_W-1:0] core_ovl_wdata_i,
  output logic [DATA_W-1:0]      ovl_rdata_o,
  output logic                   short_read_only_o,
  input  wire logic              host_port_strap_i,
  output logic                   host_port_mode_o,
  input  wire logic [DATA_W-1:0] ext_addr_i,
  input  wire logic              ext_addr_oe_i,
  output logic [DATA_W-1:0]      shared_pin_o,
  output logic                   shared_pin_oe_o,
  output logic                   mem_rd_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   mem_pm_o,
  input  wire logic [PM_W-1:0]   mem_rdata_i,
  input  wire logic              mem_rvalid_i
);
  typedef struct packed {
    hdp_state_e        state;
    logic [DATA_W-1:0] ovl;
    logic [DATA_W-1:0] drive;
    logic [DATA_W-1:0] next_word;
    logic              pending;
    logic              strap_done;
    logic              host_mode;
  } hdp_port_s;

  hdp_port_s   st;
  hdp_port_s   next_st;
  hdp_fetch_if fi ();

  logic access;
  logic sro;
  logic port_ad_oe;

  assign access = !port_select_n_i && !port_read_strobe_n_i;
  assign sro    = st.ovl[SRO_BIT];

  function automatic logic ovl_hit(input logic wr, input logic [ADDR_W-1:0] addr);
    return wr && (addr == OVL_ADDR);
  endfunction

  always_comb begin
    next_st = st;
    fi.req   = 1'b0;
    fi.is_pm = port_is_pm_i;
    fi.addr  = port_addr_i;

    // either agent may write; the host write lands last when both collide
    if (ovl_hit(core_ovl_wr_i, core_ovl_addr_i)) begin
      next_st.ovl = core_ovl_wdata_i;
    end
    if (ovl_hit(host_ovl_wr_i, host_ovl_addr_i)) begin
      next_st.ovl = host_ovl_wdata_i;
    end

    // straps are caught on the first edge after reset release, then frozen
    if (!st.strap_done) begin
      next_st.strap_done = 1'b1;
      next_st.host_mode  = host_port_strap_i;
    end

    unique case (st.state)
      HDP_IDLE: begin
        if (st.pending) begin
          next_st.drive   = st.next_word;
          next_st.pending = 1'b0;
        end
        if (access) begin
          fi.req        = 1'b1;
          next_st.state = HDP_FETCH;
        end
      end
      HDP_FETCH: begin
        if (fi.done) begin
          if (access && !sro) begin
            next_st.drive = fi.word;
            next_st.state = HDP_HOLD;
          end else begin
            // host ended early or mode keeps previous data: swap at access end
            next_st.next_word = fi.word;
            next_st.pending   = 1'b1;
            next_st.state     = access ? HDP_HOLD : HDP_IDLE;
          end
        end
      end
      HDP_HOLD: begin
        if (!access) begin
          next_st.state = HDP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st            <= '0;
      st.state      <= HDP_IDLE;
      st.ovl        <= OVL_RESET;
      st.drive      <= DRIVE_RESET;
      st.next_word  <= DRIVE_RESET;
    end else begin
      st <= next_st;
    end
  end

  hdp_fetch u_fetch (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .fi           (fi.unit),
    .mem_rd_o     (mem_rd_o),
    .mem_addr_o   (mem_addr_o),
    .mem_pm_o     (mem_pm_o),
    .mem_rdata_i  (mem_rdata_i),
    .mem_rvalid_i (mem_rvalid_i)
  );

  // ack is combinational so busy shows in the cycle the access is seen
  assign port_ack_n_o = (st.state == HDP_FETCH) ||
                        ((st.state == HDP_IDLE) && access);
  // bus follows the strobes directly, so it lets go in the cycle access ends
  assign port_ad_oe        = access && st.host_mode;
  assign shared_pin_o      = st.host_mode ? st.drive : ext_addr_i;
  assign shared_pin_oe_o   = st.host_mode ? port_ad_oe : ext_addr_oe_i;
  assign ovl_rdata_o       = st.ovl;
  assign short_read_only_o = sro;
  assign host_port_mode_o  = st.host_mode;

  // checks below watch the port from the device side of the pins
  chk_ack_on_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == HDP_IDLE && access) |-> (port_ack_n_o ##1 st.state == HDP_FETCH))
    else $error("ack not raised at read start");

  chk_prev_on_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.host_mode && st.state == HDP_IDLE && !st.pending && access)
      |-> (shared_pin_oe_o && shared_pin_o == st.drive))
    else $error("previous word not driven at read start");

  chk_sro_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sro && st.host_mode && access && st.state != HDP_IDLE && $past(access))
      |-> $stable(shared_pin_o))
    else $error("word changed during short-read-only access");

  chk_bus_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.host_mode && $past(access) && !access) |-> !shared_pin_oe_o)
    else $error("bus still driven after read end");

  chk_long_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == HDP_FETCH && fi.done && access && !sro)
      |=> (shared_pin_o == $past(fi.word) && st.state == HDP_HOLD))
    else $error("long read ack without new word");

  chk_sro_by_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(sro) |-> $past(ovl_hit(core_ovl_wr_i, core_ovl_addr_i) ||
                            ovl_hit(host_ovl_wr_i, host_ovl_addr_i)))
    else $error("short-read-only changed without overlay write");

  chk_strap_frozen: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.strap_done |=> ($stable(host_port_mode_o) ##1 $stable(host_port_mode_o)))
    else $error("strap state moved after capture");

  chk_pin_mux: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!host_port_mode_o) |-> (shared_pin_o == ext_addr_i && shared_pin_oe_o == ext_addr_oe_i))
    else $error("shared pins not on external memory function");

  chk_ack_busy_fetch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == HDP_FETCH) |-> port_ack_n_o)
    else $error("ack not busy while fetching");

  chk_ack_ready_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == HDP_HOLD) |-> !port_ack_n_o)
    else $error("ack not ready once the word is served");

  chk_ack_ready_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == HDP_IDLE && !access) |-> !port_ack_n_o)
    else $error("ack busy while no read is open");

  chk_single_fetch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state != HDP_IDLE) |-> !fi.req)
    else $error("fetch requested outside a read start");

  chk_fetch_on_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == HDP_IDLE && access) |=> (mem_rd_o || fi.done))
    else $error("read start issued no fetch");

  chk_pending_swap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == HDP_IDLE && st.pending)
      |=> (st.drive == $past(st.next_word) && !st.pending))
    else $error("held word not moved to pins after read end");

  chk_sro_keeps_prev: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sro && st.state == HDP_FETCH && fi.done) |=> (st.drive == $past(st.drive)))
    else $error("short-read-only replaced the driven word early");

  chk_host_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ovl_hit(core_ovl_wr_i, core_ovl_addr_i) && ovl_hit(host_ovl_wr_i, host_ovl_addr_i))
      |=> (ovl_rdata_o == $past(host_ovl_wdata_i)))
    else $error("colliding overlay writes not resolved to host");

  chk_released_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.host_mode && !access) |-> !shared_pin_oe_o)
    else $error("bus driven with no read open");
endmodule // hdp_read_port

// ---- pkg/hdp_pkg.sv ----
// shared constants and types of the host dma port read path
// assumes one 100 MHz clock; address latching and write cycles live next door
package hdp_pkg;
  localparam int          ADDR_W      = 14;
  localparam int          DATA_W      = 16;
  localparam int          PM_W        = 24;
  localparam int          PM_LOW_W    = PM_W - DATA_W;
  localparam logic [13:0] OVL_ADDR    = 14'h3fe7;
  localparam int          SRO_BIT     = 14;
  localparam logic [15:0] OVL_RESET   = 16'h0000;
  localparam logic [15:0] DRIVE_RESET = 16'h0000;

  typedef enum logic [2:0] {
    HDP_IDLE  = 3'b001,
    HDP_FETCH = 3'b010,
    HDP_HOLD  = 3'b100
  } hdp_state_e;
endpackage

// ---- pkg/hdp_fetch_if.sv ----
// carrier between the read sequencer and the memory fetch unit
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface hdp_fetch_if;
  logic        req;
  logic        is_pm;
  logic [13:0] addr;
  logic        done;
  logic [15:0] word;
  modport seq (output req, output is_pm, output addr, input done, input word);
  modport unit (input req, input is_pm, input addr, output done, output word);
endinterface

// ---- rtl/hdp_fetch.sv ----
// memory fetch unit: one request gives one 16-bit port word
// assumes memory answers a read strobe with rvalid some cycles later
`timescale 1ns/100ps
module hdp_fetch
  import hdp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  hdp_fetch_if.unit              fi,
  output logic                   mem_rd_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   mem_pm_o,
  input  wire logic [PM_W-1:0]   mem_rdata_i,
  input  wire logic              mem_rvalid_i
);
  typedef struct packed {
    logic                busy;
    logic                half;
    logic [PM_LOW_W-1:0] low;
    logic [DATA_W-1:0]   word;
    logic                done;
    logic [ADDR_W-1:0]   addr;
    logic                pm;
  } hdp_fetch_s;

  hdp_fetch_s st;
  hdp_fetch_s next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (st.busy) begin
      if (mem_rvalid_i) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        if (st.pm) begin
          next_st.word = mem_rdata_i[PM_W-1:PM_LOW_W];
          next_st.low  = mem_rdata_i[PM_LOW_W-1:0];
          next_st.half = 1'b1;
        end else begin
          next_st.word = mem_rdata_i[DATA_W-1:0];
          next_st.half = 1'b0;
        end
      end
    end else if (fi.req) begin
      if (fi.is_pm && st.half) begin
        // second half comes from the stored low byte; no memory cycle
        next_st.word = {{(DATA_W-PM_LOW_W){1'b0}}, st.low};
        next_st.half = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.busy = 1'b1;
        next_st.addr = fi.addr;
        next_st.pm   = fi.is_pm;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fi.done    = st.done;
  assign fi.word    = st.word;
  assign mem_rd_o   = st.busy;
  assign mem_addr_o = st.addr;
  assign mem_pm_o   = st.pm;

  chk_pm_second_half: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (fi.req && fi.is_pm && st.half && !st.busy) |=> (fi.done && !mem_rd_o))
    else $error("second program half did not come from the stored byte");
endmodule // hdp_fetch

// ---- tb/hdp_mem_model.sv ----
// memory model: answers a held fetch read after a fixed latency
// assumes mem_rd_o stays high until rvalid is seen; data is scrambled otherwise
`timescale 1ns/100ps
module hdp_mem_model #(
  parameter int LAT = 3
) (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic [13:0] addr_i,
  output logic [23:0]      rdata_o,
  output logic             rvalid_o
);
  int cnt = 0;
  initial rdata_o = 24'h000000;
  initial rvalid_o = 1'b0;
  always @(posedge clk_i) begin
    rvalid_o <= 1'b0;
    // stale data must not look valid, so it flips every cycle
    rdata_o  <= ~rdata_o;
    if (rd_i && !rvalid_o) begin
      cnt <= cnt + 1;
      if (cnt == LAT) begin
        rvalid_o <= 1'b1;
        rdata_o  <= {10'h2a5, addr_i};
        cnt      <= 0;
      end
    end
  end
endmodule // hdp_mem_model

// ---- tb/host_dma_port_read_path_tb.sv ----
// bench for the host dma port read path: strobes, overlay writes, strap
// assumes the memory model answers every fetch; host strobes move at negedge
`timescale 1ns/100ps
module host_dma_port_read_path_tb;
  import hdp_pkg::*;
  logic clk_i = 0, rst_n_i = 0, port_select_n_i = 1, port_read_strobe_n_i = 1;
  logic [13:0] port_addr_i = 0, host_ovl_addr_i = 0, core_ovl_addr_i = 0, mem_addr_o;
  logic port_is_pm_i = 0, host_ovl_wr_i = 0, core_ovl_wr_i = 0, host_port_strap_i = 1;
  logic [15:0] host_ovl_wdata_i = 0, core_ovl_wdata_i = 0, ovl_rdata_o, shared_pin_o;
  logic [15:0] ext_addr_i = 16'h5a5a;
  logic ext_addr_oe_i = 0, port_ack_n_o, short_read_only_o, host_port_mode_o;
  logic shared_pin_oe_o, mem_rd_o, mem_pm_o, mem_rvalid_i;
  logic [23:0] mem_rdata_i;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  hdp_read_port i_dut (.clk_i, .rst_n_i, .port_select_n_i, .port_read_strobe_n_i,
    .port_addr_i, .port_is_pm_i, .port_ack_n_o, .host_ovl_wr_i, .host_ovl_addr_i,
    .host_ovl_wdata_i, .core_ovl_wr_i, .core_ovl_addr_i, .core_ovl_wdata_i, .ovl_rdata_o,
    .short_read_only_o, .host_port_strap_i, .host_port_mode_o, .ext_addr_i, .ext_addr_oe_i,
    .shared_pin_o, .shared_pin_oe_o, .mem_rd_o, .mem_addr_o, .mem_pm_o, .mem_rdata_i,
    .mem_rvalid_i);
  hdp_mem_model i_mem (.clk_i, .rd_i(mem_rd_o), .addr_i(mem_addr_o), .rdata_o(mem_rdata_i),
    .rvalid_o(mem_rvalid_i));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // h: 0 data word, 1 first program half, 2 second program half
  function automatic logic [15:0] wd(input logic [13:0] a, input int h);
    logic [23:0] w;
    w = {10'h2a5, a};
    return (h == 0) ? w[15:0] : (h == 1) ? w[23:8] : {8'h00, w[7:0]};
  endfunction
  task automatic ovl(input logic host, input logic [13:0] a, input logic [15:0] d);
    @(negedge clk_i);
    if (host) {host_ovl_wr_i, host_ovl_addr_i, host_ovl_wdata_i} = {1'b1, a, d};
    else {core_ovl_wr_i, core_ovl_addr_i, core_ovl_wdata_i} = {1'b1, a, d};
    @(negedge clk_i);
    host_ovl_wr_i = 0;
    core_ovl_wr_i = 0;
  endtask
  task automatic rd(input logic [13:0] a, input logic pm, input logic [15:0] prev, fin);
    int k;
    @(negedge clk_i);
    chk({15'h0, port_ack_n_o}, 16'h0000);
    {port_select_n_i, port_read_strobe_n_i, port_addr_i, port_is_pm_i} = {2'b00, a, pm};
    #1 chk({15'h0, port_ack_n_o}, 16'h0001);
    chk({15'h0, shared_pin_oe_o}, 16'h0001);
    chk(shared_pin_o, prev);
    for (k = 0; k < 40 && port_ack_n_o !== 1'b0; k++) @(negedge clk_i);
    chk(shared_pin_o, fin);
    port_read_strobe_n_i = 1;
    #1 chk({15'h0, shared_pin_oe_o}, 16'h0000);
    @(negedge clk_i);
    port_select_n_i = 1;
    @(negedge clk_i);
  endtask
  task automatic s_reset();
    chk(ovl_rdata_o, OVL_RESET);
    chk({15'h0, short_read_only_o}, 16'h0000);
    chk({15'h0, host_port_mode_o}, 16'h0001);
  endtask
  task automatic s_long_pm();
    rd(14'h0123, 0, DRIVE_RESET, wd(14'h0123, 0));
    rd(14'h0456, 0, wd(14'h0123, 0), wd(14'h0456, 0));
    rd(14'h1abc, 1, wd(14'h0456, 0), wd(14'h1abc, 1));
    rd(14'h1abc, 1, wd(14'h1abc, 1), wd(14'h1abc, 2));
  endtask
  task automatic s_sro();
    ovl(1, OVL_ADDR, 16'h4000);
    chk(ovl_rdata_o, 16'h4000);
    chk({15'h0, short_read_only_o}, 16'h0001);
    ovl(0, 14'h3fe6, 16'h0000);
    chk({15'h0, short_read_only_o}, 16'h0001);
    rd(14'h0077, 0, wd(14'h1abc, 2), wd(14'h1abc, 2));
    rd(14'h0088, 0, wd(14'h0077, 0), wd(14'h0077, 0));
    ovl(0, OVL_ADDR, 16'h0000);
    chk({15'h0, short_read_only_o}, 16'h0000);
    rd(14'h0099, 0, wd(14'h0088, 0), wd(14'h0099, 0));
  endtask
  // second reset with the strap low: pins must fall back to the memory function
  task automatic s_strap();
    @(negedge clk_i);
    {host_port_strap_i, ext_addr_oe_i, rst_n_i} = 3'b010;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1;
    repeat (3) @(negedge clk_i);
    chk({15'h0, host_port_mode_o}, 16'h0000);
    chk(shared_pin_o, ext_addr_i);
    chk({15'h0, shared_pin_oe_o}, 16'h0001);
    chk(ovl_rdata_o, OVL_RESET);
    host_port_strap_i = 1;
    repeat (2) @(negedge clk_i);
    chk({15'h0, host_port_mode_o}, 16'h0000);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1;
    repeat (3) @(negedge clk_i);
    s_reset();
    s_long_pm();
    s_sro();
    s_strap();
    end_sim();
  end
endmodule // host_dma_port_read_path_tb
